// [tre_pkg.sv]
package tre_pkg;
    // digit and word geometry
    localparam int             NUM_TRITS      = 9;
    localparam int             NUM_ADDR       = 5;
    localparam int             NUM_SHARED     = 4;
    localparam int             TRIT_W         = 2;
    localparam int             IDX_W          = 4;
    localparam logic [3:0]     LAST_IDX       = 4'h8;
    localparam int             CODE_SPACE     = 19683;
    // trit encodings
    localparam logic [1:0]     TRIT_LOW       = 2'h0;
    localparam logic [1:0]     TRIT_HIGH      = 2'h1;
    localparam logic [1:0]     TRIT_OPEN      = 2'h2;
    // pulse shaping, in oscillator cycles per half digit
    localparam logic [3:0]     HALF_CYCLES    = 4'h8;
    localparam logic [3:0]     SHORT_CYCLES   = 4'h2;
    localparam logic [3:0]     LONG_CYCLES    = 4'h6;
    localparam logic [3:0]     PERIOD_CYCLES  = 4'h8;
    // gap between the two words of a sequence, in data periods
    localparam logic [1:0]     GAP_PERIODS    = 2'h3;
    localparam logic [1:0]     WORDS_PER_SEQ  = 2'h2;
    // probe settling, in clock cycles
    localparam logic [1:0]     SETTLE_CYCLES  = 2'h2;
    localparam int             FIFO_DEPTH     = 16;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PROBE_HI,
        ST_PROBE_LO,
        ST_FIRST_HALF,
        ST_SECOND_HALF,
        ST_GAP
    } tre_state_t;
endpackage : tre_pkg

// [tre_fifo_if.sv]
`timescale 1ns/10ps
interface tre_fifo_if #(parameter int WIDTH = 2);
    logic             inValid;
    logic             inReady;
    logic [WIDTH-1:0] inData;
    logic             outValid;
    logic             outReady;
    logic [WIDTH-1:0] outData;
    modport fifo (input inValid, inData, outReady,
                  output inReady, outValid, outData);
    modport user (output inValid, inData, outReady,
                  input inReady, outValid, outData);
endinterface : tre_fifo_if

// [tre_fifo.sv]
`timescale 1ns/10ps
module tre_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    // clocking
    input wire logic  clk,
    input wire logic  rst_b,
    input wire logic  clkEn,
    input wire logic  flush,
    // streams
    tre_fifo_if.fifo  port
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_reg;
    logic [AW:0]      rdPtr_reg;
    logic [WIDTH-1:0] outData_reg;
    logic             outValid_reg;

    wire logic [AW:0] used  = wrPtr_reg - rdPtr_reg;
    wire logic        full  = used == (AW + 1)'(DEPTH);
    wire logic        empty = used == '0;
    wire logic        push  = port.inValid && !full;
    // output register refills when empty or being taken
    wire logic        load  = !empty && (!outValid_reg || port.outReady);
    wire logic        drop  = outValid_reg && port.outReady && !load;

    assign port.inReady  = !full;
    assign port.outValid = outValid_reg;
    assign port.outData  = outData_reg;

    always_ff @(posedge clk) begin
        if (clkEn && push) begin
            mem[wrPtr_reg[AW-1:0]] <= port.inData;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_reg    <= '0;
            rdPtr_reg    <= '0;
            outData_reg  <= '0;
            outValid_reg <= 1'b0;
        end else if (clkEn) begin
            if (flush) begin
                wrPtr_reg    <= '0;
                rdPtr_reg    <= '0;
                outValid_reg <= 1'b0;
            end else begin
                if (push) wrPtr_reg <= wrPtr_reg + 1'b1;
                if (load) begin
                    outData_reg  <= mem[rdPtr_reg[AW-1:0]];
                    outValid_reg <= 1'b1;
                    rdPtr_reg    <= rdPtr_reg + 1'b1;
                end else if (drop) begin
                    outValid_reg <= 1'b0;
                end
            end
        end
    end
endmodule : tre_fifo

// [tre_encoder.sv]
`timescale 1ns/10ps
// Operation
// [R01] nine input lines, each resolved low, high or open: 19683 words
// [R02] a low send request starts a transmit sequence
// [R03] words repeat back to back while send request stays low
// [R04] a brief low pulse still yields a full two-word sequence
// [R05] receiver must not trust the first word after power-up
// [R06] three idle data periods separate the two words of a sequence
// [R07] low digit is sent as two short pulses
// [R08] high digit is sent as two long pulses
// [R09] open digit is sent as a long pulse then a short pulse
// [R10] each line is weakly pulled high, tested, then pulled low, tested
// [R11] only high: high; only low: low; both forced: open
// [R12] send request high: block idle, no probing, no pulses
// [R13] on request: start, probe lines one at a time, shift digits out
// [R14] digits go first address input through last shared input
// [R15] short and long widths are fixed cycle counts within a period
module tre_encoder (
    // clocking
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       clkEn,
    // request
    input  wire logic       send_request_n,
    // trit lines, weak pull drive
    input  wire logic [4:0] address_trit_inputs_in,
    input  wire logic [3:0] shared_trit_inputs_in,
    output logic      [4:0] address_trit_inputs_out,
    output logic      [4:0] address_trit_inputs_oe,
    output logic      [3:0] shared_trit_inputs_out,
    output logic      [3:0] shared_trit_inputs_oe,
    // serial out
    output logic            serialOut,
    output logic            busy
);
    tre_pkg::tre_state_t state_reg;
    tre_pkg::tre_state_t state_next;

    logic [3:0] idx_reg;
    logic [1:0] settle_reg;
    logic       sawHigh_reg;
    logic [3:0] cycle_reg;
    logic [1:0] gapCnt_reg;
    logic       wordNum_reg;
    logic       pending_reg;
    logic [8:0] pullOe_reg;
    logic [8:0] pullVal_reg;
    logic       serialOut_reg;
    logic       busy_reg;
    logic [1:0] curTrit_reg;
    logic       haveTrit_reg;
    logic       probeDone_reg;

    tre_fifo_if #(.WIDTH(tre_pkg::TRIT_W)) tq ();

    // the probe runs ahead of the pulse shaper; queue absorbs skew
    tre_fifo #(
        .WIDTH (tre_pkg::TRIT_W),
        .DEPTH (tre_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk   (clk),
        .rst_b (rst_b),
        .clkEn (clkEn),
        .flush (state_reg == tre_pkg::ST_IDLE),
        .port  (tq)
    );

    function automatic logic [1:0] classify(input logic hi, input logic lo);
        // [R11]
        if (hi && !lo) classify = tre_pkg::TRIT_OPEN;
        else if (hi) classify = tre_pkg::TRIT_HIGH;
        else classify = tre_pkg::TRIT_LOW;
    endfunction : classify

    function automatic logic [3:0] pulseLen(input logic [1:0] t,
                                            input logic second);
        // [R07] [R08] [R09] [R15]
        if (t == tre_pkg::TRIT_HIGH) pulseLen = tre_pkg::LONG_CYCLES;
        else if (t == tre_pkg::TRIT_OPEN)
            pulseLen = second ? tre_pkg::SHORT_CYCLES
                              : tre_pkg::LONG_CYCLES;
        else pulseLen = tre_pkg::SHORT_CYCLES;
    endfunction : pulseLen

    // [R01] [R14] index 0..4 address, 5..8 shared
    wire logic [8:0] lineIn   = {shared_trit_inputs_in,
                                 address_trit_inputs_in};
    wire logic       lineNow  = lineIn[idx_reg];
    wire logic       settled  = settle_reg == tre_pkg::SETTLE_CYCLES;
    wire logic       request  = !send_request_n; // [R02]
    wire logic       probing  = state_reg != tre_pkg::ST_IDLE
                                && !probeDone_reg;
    wire logic       probeHi  = probing && pullVal_reg[idx_reg]
                                && pullOe_reg[idx_reg];
    wire logic       lastLine = idx_reg == tre_pkg::LAST_IDX;
    wire logic       pushNow  = probing && !probeHi && settled
                                && pullOe_reg[idx_reg];
    wire logic       periodEnd = cycle_reg == tre_pkg::PERIOD_CYCLES
                                 - 4'h1;
    wire logic       digitEnd = state_reg == tre_pkg::ST_SECOND_HALF
                                && periodEnd;
    wire logic       wordEnd  = digitEnd && tq.outValid == 1'b0
                                && probeDone_reg;
    wire logic       gapEnd   = state_reg == tre_pkg::ST_GAP && periodEnd
                                && gapCnt_reg == tre_pkg::GAP_PERIODS
                                   - 2'h1;
    wire logic       secondHalf = state_reg == tre_pkg::ST_SECOND_HALF;
    wire logic [3:0] highLen  = pulseLen(curTrit_reg, secondHalf);
    wire logic       pulseLvl = (state_reg == tre_pkg::ST_FIRST_HALF
                                 || secondHalf) && haveTrit_reg
                                && cycle_reg < highLen;

    assign tq.inValid  = pushNow;
    assign tq.inData   = classify(sawHigh_reg, lineNow);
    assign tq.outReady = (state_reg == tre_pkg::ST_IDLE
                          || state_reg == tre_pkg::ST_GAP) ? 1'b0
                         : (!haveTrit_reg || digitEnd);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            tre_pkg::ST_IDLE:
                if (request || pending_reg) state_next = tre_pkg::ST_FIRST_HALF;
            tre_pkg::ST_PROBE_HI, tre_pkg::ST_PROBE_LO,
            tre_pkg::ST_FIRST_HALF:
                if (periodEnd && haveTrit_reg)
                    state_next = tre_pkg::ST_SECOND_HALF;
            tre_pkg::ST_SECOND_HALF:
                if (wordEnd) begin
                    // [R06] gap after first word; [R03] [R04] after second
                    if (!wordNum_reg) state_next = tre_pkg::ST_GAP;
                    else if (request) state_next = tre_pkg::ST_FIRST_HALF;
                    else state_next = tre_pkg::ST_IDLE; // [R12]
                end else if (digitEnd) begin
                    state_next = tre_pkg::ST_FIRST_HALF;
                end
            tre_pkg::ST_GAP:
                if (gapEnd) state_next = tre_pkg::ST_FIRST_HALF;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= tre_pkg::ST_IDLE;
        end else if (clkEn) begin
            state_reg <= state_next;
        end
    end

    // probe engine: per line pull high, sample, pull low, sample
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            idx_reg       <= 4'h0;
            settle_reg    <= 2'h0;
            sawHigh_reg   <= 1'b0;
            pullOe_reg    <= 9'h000;
            pullVal_reg   <= 9'h000;
            probeDone_reg <= 1'b0;
        end else if (clkEn) begin
            // no restart at gap end: the second word's probe starts in the gap
            if (state_reg == tre_pkg::ST_IDLE
                || (wordEnd && state_next != tre_pkg::ST_IDLE)) begin
                idx_reg       <= 4'h0;
                settle_reg    <= 2'h0;
                pullOe_reg    <= 9'h000;
                probeDone_reg <= state_reg == tre_pkg::ST_IDLE
                                 && !(request || pending_reg);
            end else if (probing && tq.inReady) begin
                if (!pullOe_reg[idx_reg]) begin
                    // [R10] weak high drive first
                    pullOe_reg[idx_reg]  <= 1'b1;
                    pullVal_reg[idx_reg] <= 1'b1;
                    settle_reg           <= 2'h0;
                end else if (!settled) begin
                    settle_reg <= settle_reg + 2'h1;
                end else if (pullVal_reg[idx_reg]) begin
                    // [R10] test high, then weak low drive
                    sawHigh_reg          <= lineNow;
                    pullVal_reg[idx_reg] <= 1'b0;
                    settle_reg           <= 2'h0;
                end else begin
                    // [R13] low test done, next line
                    pullOe_reg[idx_reg] <= 1'b0;
                    settle_reg          <= 2'h0;
                    if (lastLine) probeDone_reg <= 1'b1;
                    else idx_reg <= idx_reg + 4'h1;
                end
            end
        end
    end

    // pulse shaper and sequence bookkeeping
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cycle_reg     <= 4'h0;
            gapCnt_reg    <= 2'h0;
            wordNum_reg   <= 1'b0;
            pending_reg   <= 1'b0;
            curTrit_reg   <= tre_pkg::TRIT_LOW;
            haveTrit_reg  <= 1'b0;
            serialOut_reg <= 1'b0;
            busy_reg      <= 1'b0;
        end else if (clkEn) begin
            // [R04] latch a short request so the sequence completes
            if (request) pending_reg <= 1'b1;
            else if (state_reg != tre_pkg::ST_IDLE) pending_reg <= 1'b0;
            busy_reg      <= state_next != tre_pkg::ST_IDLE;
            serialOut_reg <= pulseLvl; // [R07] [R08] [R09]
            if (state_reg == tre_pkg::ST_IDLE) begin
                cycle_reg    <= 4'h0;
                gapCnt_reg   <= 2'h0;
                wordNum_reg  <= 1'b0;
                haveTrit_reg <= 1'b0;
            end else begin
                if (tq.outValid && tq.outReady) begin
                    curTrit_reg  <= tq.outData;
                    haveTrit_reg <= 1'b1;
                end else if (digitEnd) begin
                    haveTrit_reg <= 1'b0;
                end
                // cycle count only advances with a digit in hand or in the gap
                if (haveTrit_reg || state_reg == tre_pkg::ST_GAP)
                    cycle_reg <= periodEnd ? 4'h0 : cycle_reg + 4'h1;
                if (state_reg == tre_pkg::ST_GAP && periodEnd)
                    gapCnt_reg <= gapCnt_reg + 2'h1; // [R06]
                if (wordEnd) begin
                    wordNum_reg <= !wordNum_reg;
                    gapCnt_reg  <= 2'h0;
                end
            end
        end
    end

    assign address_trit_inputs_out = pullVal_reg[4:0];
    assign address_trit_inputs_oe  = pullOe_reg[4:0];
    assign shared_trit_inputs_out  = pullVal_reg[8:5];
    assign shared_trit_inputs_oe   = pullOe_reg[8:5];
    assign serialOut               = serialOut_reg;
    assign busy                    = busy_reg;
endmodule : tre_encoder

// [tre_line_model.sv]
`timescale 1ns/10ps
module tre_line_model (
    // clocking
    input wire logic        clk,
    // line setup, two bits a line
    input wire logic [17:0] cfg,
    // device side
    input wire logic [8:0]  pinOut,
    input wire logic [8:0]  pinOe,
    output logic     [8:0]  level
);
    // undriven open line wanders, so a stale value never reads back
    logic [8:0] floatReg = 9'h0aa;
    always @(posedge clk) floatReg <= ~floatReg;
    always_comb begin
        for (int i = 0; i < 9; i++) begin
            case (cfg[2*i +: 2])
                tre_pkg::TRIT_LOW:  level[i] = 1'b0;
                tre_pkg::TRIT_HIGH: level[i] = 1'b1;
                // weak pull wins only on an open line
                default: level[i] = pinOe[i] ? pinOut[i] : floatReg[i];
            endcase
        end
    end
endmodule : tre_line_model

// [tre_encoder_asserts.sv]
`timescale 1ns/10ps
module tre_encoder_asserts (
    // clocking
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       clkEn,
    // request
    input wire logic       send_request_n,
    // trit lines
    input wire logic [4:0] address_trit_inputs_in,
    input wire logic [3:0] shared_trit_inputs_in,
    input wire logic [4:0] address_trit_inputs_out,
    input wire logic [4:0] address_trit_inputs_oe,
    input wire logic [3:0] shared_trit_inputs_out,
    input wire logic [3:0] shared_trit_inputs_oe,
    // serial out
    input wire logic       serialOut,
    input wire logic       busy
);
    wire [8:0] allOe = {shared_trit_inputs_oe, address_trit_inputs_oe};
    default clocking @(posedge clk); endclocking
    // frozen cycles are not judged
    default disable iff (!rst_b || !clkEn);
    sequence idleTwo;
        !busy [*2];
    endsequence
    sequence pulseStart;
        !serialOut ##1 serialOut;
    endsequence
    start_busy_a: assert property (!busy && !send_request_n && clkEn |=> busy)
        else $error("request did not start a sequence");
    busy_hold_a: assert property (busy && !send_request_n |=> busy)
        else $error("sequence stopped while request low");
    quiet_idle_a: assert property (idleTwo |-> !serialOut && allOe == 9'h0)
        else $error("activity while idle");
    first_probe_a: assert property ($rose(busy) |=>
        address_trit_inputs_oe[0] && address_trit_inputs_out[0])
        else $error("first probe not a pull high on line 0");
    one_line_a: assert property ($onehot0(allOe))
        else $error("more than one line probed");
    pulse_min_a: assert property (pulseStart |=> serialOut)
        else $error("pulse shorter than short width");
    pulse_max_a: assert property ($rose(serialOut) |-> ##[1:6] !serialOut)
        else $error("pulse longer than long width");
    low_min_a: assert property ($fell(serialOut) |-> !serialOut [*2])
        else $error("space between pulses too short");
    pulse_busy_a: assert property (serialOut |-> busy)
        else $error("pulse outside a sequence");
endmodule : tre_encoder_asserts

// [tb.sv]
`timescale 1ns/10ps
module tb;
    localparam logic [17:0] MIX = {tre_pkg::TRIT_HIGH, tre_pkg::TRIT_LOW,
        tre_pkg::TRIT_OPEN, tre_pkg::TRIT_OPEN, tre_pkg::TRIT_LOW,
        tre_pkg::TRIT_HIGH, tre_pkg::TRIT_OPEN, tre_pkg::TRIT_HIGH,
        tre_pkg::TRIT_LOW};
    logic [17:0] pat [3] = '{{9{tre_pkg::TRIT_LOW}},
        {9{tre_pkg::TRIT_HIGH}}, {9{tre_pkg::TRIT_OPEN}}};
    logic        clk;
    logic        rst_b;
    logic        clkEn;
    logic        sendReqN;
    logic [17:0] cfg;
    logic [8:0]  lvl;
    logic [4:0]  aOut, aOe;
    logic [3:0]  sOut, sOe;
    logic        serialOut, busy;
    int          err_total, num_checks, cyc, hiRun, loRun;
    int          widths[$];
    int          lows[$];
    tre_encoder i_dut (.clk(clk), .rst_b(rst_b), .clkEn(clkEn),
        .send_request_n(sendReqN), .address_trit_inputs_in(lvl[4:0]),
        .shared_trit_inputs_in(lvl[8:5]), .address_trit_inputs_out(aOut),
        .address_trit_inputs_oe(aOe), .shared_trit_inputs_out(sOut),
        .shared_trit_inputs_oe(sOe), .serialOut(serialOut), .busy(busy));
    tre_line_model i_lines (.clk(clk), .cfg(cfg), .pinOut({sOut, aOut}),
        .pinOe({sOe, aOe}), .level(lvl));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // pulse widths and preceding spaces, sampled mid-cycle
    always @(negedge clk) begin
        if (serialOut === 1'b1) begin
            if (hiRun == 0) lows.push_back(loRun);
            hiRun++;
            loRun = 0;
        end else begin
            if (hiRun != 0) widths.push_back(hiRun);
            hiRun = 0;
            loRun++;
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [31:0] exp_w(input logic [17:0] c, input int k);
        logic [1:0] t;
        t = c[2*(k/2) +: 2];
        if (t == tre_pkg::TRIT_HIGH || (t == tre_pkg::TRIT_OPEN && k%2 == 0))
            return 32'(tre_pkg::LONG_CYCLES);
        return 32'(tre_pkg::SHORT_CYCLES);
    endfunction : exp_w
    // hold == 1 is a brief pulse, anything longer a held request
    task automatic run_seq(input logic [17:0] c, input int hold,
                           input logic judge);
        int k;
        cfg = c;
        widths.delete();
        lows.delete();
        sendReqN = 1'b0;
        repeat (hold) @(negedge clk);
        sendReqN = 1'b1;
        repeat (3) @(negedge clk);
        k = 0;
        while (busy !== 1'b0 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        repeat (40) @(negedge clk);
        if (!judge) return;
        if (hold == 1) check(widths.size(), 36);
        else check(widths.size() >= 54 && widths.size() % 36 == 0, 1);
        foreach (widths[i]) check(widths[i], exp_w(c, i % 18));
        if (lows.size() > 18) check(lows[18] >= 24 && lows[18] < 40, 1);
    endtask : run_seq
    // freeze mid-sequence; widths are stretched, so only the hold is judged
    task automatic freeze_hold();
        logic [10:0] snap;
        cfg = MIX;
        sendReqN = 1'b0;
        @(negedge clk);
        sendReqN = 1'b1;
        repeat (30) @(negedge clk);
        clkEn = 1'b0;
        @(negedge clk);
        snap = {serialOut, busy, sOe, aOe};
        repeat (20) @(negedge clk);
        check({serialOut, busy, sOe, aOe}, snap);
        clkEn = 1'b1;
        while (busy !== 1'b0) @(negedge clk);
        repeat (40) @(negedge clk);
    endtask : freeze_hold
    task automatic idle_quiet();
        widths.delete();
        repeat (100) @(negedge clk);
        check(widths.size(), 0);
        check({sOe, aOe}, 0);
        check(busy, 0);
    endtask : idle_quiet
    task automatic results();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results
    initial begin
        rst_b = 1'b0;
        clkEn = 1'b1;
        sendReqN = 1'b1;
        cfg = MIX;
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        // first words after power-up are not judged
        run_seq(MIX, 1, 1'b0);
        idle_quiet();
        run_seq(MIX, 1, 1'b1);
        foreach (pat[i]) run_seq(pat[i], 1, 1'b1);
        run_seq(MIX, 600, 1'b1);
        freeze_hold();
        idle_quiet();
        results();
    end
endmodule : tb
bind tre_encoder tre_encoder_asserts i_chk (.clk(clk), .rst_b(rst_b),
    .clkEn(clkEn), .send_request_n(send_request_n),
    .address_trit_inputs_in(address_trit_inputs_in),
    .shared_trit_inputs_in(shared_trit_inputs_in),
    .address_trit_inputs_out(address_trit_inputs_out),
    .address_trit_inputs_oe(address_trit_inputs_oe),
    .shared_trit_inputs_out(shared_trit_inputs_out),
    .shared_trit_inputs_oe(shared_trit_inputs_oe),
    .serialOut(serialOut), .busy(busy));
